// ---- bench/gtu_pin_model.sv ----
// Behavioural model of the external count, direction and capture pins.
`timescale 1ns/1ps
`default_nettype none
module gtu_pin_model (
  input wire logic pclk, // System clock.
  output var gtu_pkg::gtu_pins_s pins // Pin levels toward the unit.
);
  // ----------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------
  // Each level is held six cycles, so a first-module slot never merges two events.
  initial pins = '0;
  task automatic hold();
    repeat (6) @(posedge pclk);
  endtask
  task automatic cnt(input int k, input logic v);
    pins.timer_count_gate_pin[k] <= v;
    hold();
  endtask
  task automatic dir(input int k, input logic v);
    pins.timer_direction_pin[k] <= v;
    hold();
  endtask
  task automatic pulse(input int k);
    cnt(k, 1'b1);
    cnt(k, 1'b0);
  endtask
  task automatic cap();
    pins.capture_trigger_pin <= 1'b1;
    hold();
    pins.capture_trigger_pin <= 1'b0;
    hold();
  endtask
  // One encoder period with phase A leading, which is four forward steps.
  task automatic quad(input int k);
    cnt(k, 1'b1);
    dir(k, 1'b1);
    cnt(k, 1'b0);
    dir(k, 1'b0);
  endtask
endmodule
`default_nettype wire

// ---- bench/gtu_timer_unit_asserts.sv ----
// Port-level checks for the general timer unit.
`timescale 1ns/1ps
`default_nettype none
module gtu_timer_unit_asserts #(
  parameter int AW = 8 // Address width.
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // Select.
  input wire logic penable, // Access phase.
  input wire logic pwrite, // Direction.
  input wire logic [AW-1:0] paddr, // Address.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic first_core_latch_pin, // First latch pin.
  input wire logic ccu_clock_en // Compare unit tick.
);
  // ----------------------------------------------------------
  // Helpers and properties
  // ----------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic hit;
  logic [2:0] gap_r;
  assign acc = psel && penable;
  assign hit = paddr[1:0] == 2'h0 && paddr <= 8'h2C;
  // Bus traffic may legally move the latch pin, so it sets the spacing count to its ceiling of 7.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      gap_r <= 3'h7;
    else if (psel)
      gap_r <= 3'h7;
    else if ($changed(first_core_latch_pin))
      gap_r <= 3'h0;
    else if (gap_r != 3'h7)
      gap_r <= gap_r + 3'h1;
  end
  chk_ready_high: assert property (pready) else $error("ready low");
  chk_err_unmapped: assert property (acc && !hit |-> pslverr)
    else $error("no error on unmapped address");
  chk_err_mapped: assert property (acc && hit |-> !pslverr)
    else $error("error on mapped address");
  chk_err_idle: assert property (!acc |-> !pslverr)
    else $error("error outside access");
  chk_rd_upper: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  chk_rd_err_zero: assert property (acc && !pwrite && !hit |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rd_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  chk_core1_rate: assert property ($changed(first_core_latch_pin) |-> gap_r >= 3'h3)
    else $error("first core wrapped too fast");
  cov_tick: cover property (ccu_clock_en);
  cov_latch: cover property ($rose(first_core_latch_pin));
  cov_err: cover property (pslverr);
endmodule
`default_nettype wire

// ---- bench/gtu_timer_unit_tb_top.sv ----
// Self-checking bench for the general timer unit.
`timescale 1ns/1ps
`default_nettype none
module gtu_timer_unit_tb_top;
  // ----------------------------------------------------------
  // Signals, instances and tasks
  // ----------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, l1, l2, tick;
  gtu_pkg::gtu_pins_s pins;
  logic [32:0] exp_q[$];
  int failures = 0;
  int n_compared = 0;
  logic [15:0] v, w;
  int n;
  always #2 pclk = ~pclk;
  gtu_timer_unit #(.AW(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .first_core_latch_pin(l1), .second_core_latch_pin(l2), .ccu_clock_en(tick));
  gtu_pin_model u_pins (.pclk(pclk), .pins(pins));
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= we;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    xfer(1'b0, a, 32'h0, {17'h0, e});
  endtask
  function automatic logic [31:0] mk(input gtu_pkg::gtu_mode_e m, input logic [2:0] pre,
    input logic [1:0] es, input logic [1:0] sel, input logic [4:0] f);
    gtu_pkg::gtu_ctrl_s c;
    c = '0;
    c.mode = m;
    c.pre = pre;
    c.edge_sel = es;
    c.sel = sel;
    {c.clr_cap, c.lat_oe, c.lat_clk, c.ext_dir, c.run} = f;
    return {16'h0, c};
  endfunction
  always @(posedge pclk) begin
    if (psel && penable && pready && exp_q.size() > 0)
      check({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    wrap_up();
  end
  initial begin
    void'($urandom(76309));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 12; k++)
      rd(8'(4 * k), 16'h0);
    xfer(1'b0, 8'h30, 32'h0, {1'b1, 32'h0});
    xfer(1'b1, 8'h02, 32'hFFFF, {1'b1, 32'h0});
    rd(8'h00, 16'h0);
    v = 16'($urandom);
    pstrb <= 4'h1;
    wr(8'h10, {16'h0, v});
    pstrb <= 4'h2;
    wr(8'h10, {16'h0, ~v});
    pstrb <= 4'hF;
    rd(8'h10, {~v[15:8], v[7:0]});
    v = 16'($urandom);
    n = 1 + $urandom % 4;
    wr(8'h0C, {16'h0, v});
    wr(8'h20, mk(gtu_pkg::mode_counter, 3'h0, 2'h1, 2'h0, 5'h01));
    repeat (n) u_pins.pulse(3);
    rd(8'h0C, v + 16'(n));
    wr(8'h20, mk(gtu_pkg::mode_counter, 3'h0, 2'h1, 2'h0, 5'h03));
    u_pins.dir(3, 1'b1);
    repeat (2) u_pins.pulse(3);
    rd(8'h0C, v + 16'(n) - 16'h2);
    wr(8'h14, mk(gtu_pkg::mode_incr, 3'h0, 2'h0, 2'h0, 5'h01));
    u_pins.quad(0);
    rd(8'h00, 16'h4);
    w = 16'($urandom);
    wr(8'h00, {16'h0, w});
    wr(8'h14, mk(gtu_pkg::mode_reload, 3'h0, 2'h1, 2'h0, 5'h01));
    u_pins.pulse(0);
    rd(8'h04, w);
    rd(8'h00, w);
    wr(8'h1C, mk(gtu_pkg::mode_capture, 3'h0, 2'h1, 2'h0, 5'h01));
    u_pins.pulse(2);
    rd(8'h08, w);
    wr(8'h1C, mk(gtu_pkg::mode_gate_hi, 3'h0, 2'h0, 2'h0, 5'h01));
    // Twelve open cycles hold exactly three ticks of the four-cycle prescale.
    u_pins.cnt(2, 1'b1);
    u_pins.hold();
    u_pins.cnt(2, 1'b0);
    rd(8'h08, w + 16'h3);
    wr(8'h00, {17'h0, w[14:0]});
    wr(8'h14, mk(gtu_pkg::mode_counter, 3'h0, 2'h1, 2'h0, 5'h05));
    wr(8'h2C, 32'h3F);
    wr(8'h04, 32'hFFFF);
    wr(8'h18, mk(gtu_pkg::mode_timer, 3'h0, 2'h0, 2'h0, 5'h09));
    for (int i = 0; i < 40 && l1 !== 1'b1; i++)
      @(posedge pclk);
    check({32'h0, l1}, 33'h1);
    wr(8'h18, mk(gtu_pkg::mode_timer, 3'h0, 2'h0, 2'h0, 5'h08));
    rd(8'h00, {1'b0, w[14:0]} + 16'h1);
    v = 16'($urandom);
    wr(8'h0C, {16'h0, v});
    wr(8'h20, mk(gtu_pkg::mode_timer, 3'h0, 2'h1, 2'h0, 5'h10));
    u_pins.cap();
    rd(8'h28, v);
    rd(8'h0C, 16'h0);
    rd(8'h2C, 16'h22);
    for (int s = 1; s <= 2; s++) begin
      v = 16'($urandom);
      wr(8'h0C, {16'h0, v});
      wr(8'h20, mk(gtu_pkg::mode_timer, 3'h0, 2'h1, 2'(s), 5'h10));
      u_pins.cnt(1, s == 1);
      u_pins.dir(1, s == 2);
      u_pins.cnt(1, 1'b0);
      u_pins.dir(1, 1'b0);
      rd(8'h28, v);
    end
    w = 16'($urandom);
    wr(8'h2C, 32'h3F);
    wr(8'h28, {16'h0, w});
    wr(8'h10, 32'hFFFF);
    wr(8'h24, mk(gtu_pkg::mode_timer, 3'h7, 2'h0, 2'h0, 5'h0D));
    for (int i = 0; i < 600 && tick !== 1'b1; i++)
      @(posedge pclk);
    check({32'h0, tick}, 33'h1);
    wr(8'h24, mk(gtu_pkg::mode_timer, 3'h7, 2'h0, 2'h0, 5'h0C));
    check({32'h0, l2}, 33'h1);
    rd(8'h10, w);
    rd(8'h2C, 16'h10);
    wrap_up();
  end
endmodule
bind gtu_timer_unit gtu_timer_unit_asserts #(.AW(AW)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .first_core_latch_pin(first_core_latch_pin), .ccu_clock_en(ccu_clock_en));
`default_nettype wire

// ---- design/gtu_timer_unit.sv ----
// General timer unit: five 16-bit timers in two modules behind an APB slave.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "gtu_cfg.svh"


module gtu_timer_unit #(
  parameter int AW = 8 // APB address width.
) (
  input wire logic pclk, // System clock, 250 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [AW-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready, always high.
  output logic pslverr, // APB error on unmapped address.
  input wire gtu_pkg::gtu_pins_s pins, // External count, gate, direction and capture pins.
  output logic first_core_latch_pin, // First core toggle latch output.
  output logic second_core_latch_pin, // Second core toggle latch output.
  output logic ccu_clock_en // Second core wrap pulse for the compare unit timers.
);

  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  if (AW < 6 || AW > 16) begin : g_bad_aw
    $error("gtu_timer_unit: AW must lie between 6 and 16.");
  end

  localparam int NT = 5;
  localparam int M1 = 3;
  localparam int NP = 2 * NT + 1;
  localparam logic [15:0] TOP = 16'hFFFF;
  localparam logic [11:0] MINM = 12'(`GTU_M1_MIN_CYC - 1);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  // Timer order: 0 first aux a, 1 first core, 2 first aux b,
  // 3 second aux, 4 second core.
  gtu_pkg::gtu_ctrl_s ctrl_r [NT];
  logic [15:0] cnt_r [NT];
  logic [15:0] capture_reload_register_r;
  logic [`GTU_FLG_W-1:0] flag_r;
  logic [1:0] lat_r;
  logic [11:0] pre_r;
  logic [NP-1:0] s1_r;
  logic [NP-1:0] s2_r;
  logic [NP-1:0] s3_r;
  logic [31:0] prdata_r;

  logic [NP-1:0] pin_v;
  logic [NP-1:0] rise;
  logic [NP-1:0] fall;
  logic [NT-1:0] step;
  logic [NT-1:0] dn;
  logic [NT-1:0] ovf;
  logic [NT-1:0] rl_trig;
  logic [NT-1:0] cp_trig;
  logic [1:0] lrise;
  logic [1:0] lfall;
  logic cap_trig;

  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  assign pin_v = {pins.capture_trigger_pin, pins.timer_direction_pin,
                  pins.timer_count_gate_pin};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_v;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Edges are taken between the second and third stage only.
  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;

  // ------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 12'h000;
    end else begin
      pre_r <= pre_r + 12'h001;
    end
  end

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  logic acc;
  logic wr;
  logic hit;
  logic cap_sel;
  logic flg_sel;
  logic [NT-1:0] cnt_sel;
  logic [NT-1:0] ctl_sel;
  logic [31:0] rdata;

  for (genvar i = 0; i < NT; i++) begin : g_dec
    assign cnt_sel[i] = paddr == AW'(`GTU_CNT_OFS + `GTU_REG_STEP * i);
    assign ctl_sel[i] = paddr == AW'(`GTU_CTL_OFS + `GTU_REG_STEP * i);
  end

  assign cap_sel = paddr == AW'(`GTU_CAP_OFS);
  assign flg_sel = paddr == AW'(`GTU_FLG_OFS);
  assign hit = (|cnt_sel) | (|ctl_sel) | cap_sel | flg_sel;
  assign acc = psel & penable;
  assign wr = acc & pwrite & hit;
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata = prdata_r;

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [1:0] strb);
    merge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
  endfunction

  always_comb begin
    rdata = 32'h0000_0000;
    for (int k = 0; k < NT; k++) begin
      if (cnt_sel[k]) begin
        rdata = {16'h0000, cnt_r[k]};
      end
      if (ctl_sel[k]) begin
        rdata = {16'h0000, ctrl_r[k]};
      end
    end
    if (cap_sel) begin
      rdata = {16'h0000, capture_reload_register_r};
    end
    if (flg_sel) begin
      rdata = {26'h0000000, flag_r};
    end
  end

  // Read data is caught in the setup phase so the access phase can finish
  // at once; a count that moves meanwhile reads as its setup-cycle value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= rdata;
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NT; k++) begin
        ctrl_r[k] <= gtu_pkg::gtu_ctrl_s'(`GTU_CTL_RST);
      end
    end else begin
      for (int k = 0; k < NT; k++) begin
        if (wr && ctl_sel[k]) begin
          ctrl_r[k] <= gtu_pkg::gtu_ctrl_s'(merge(ctrl_r[k], pwdata[15:0], pstrb[1:0]));
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Toggle latch transitions
  // ------------------------------------------------------------
  assign lrise[0] = ovf[1] & ~lat_r[0];
  assign lfall[0] = ovf[1] & lat_r[0];
  assign lrise[1] = ovf[4] & ~lat_r[1];
  assign lfall[1] = ovf[4] & lat_r[1];

  // ------------------------------------------------------------
  // Per-timer count event logic
  // ------------------------------------------------------------
  for (genvar i = 0; i < NT; i++) begin : g_tmr
    localparam int CORE = (i < M1) ? 1 : 4;
    localparam int LI = (i < M1) ? 0 : 1;
    gtu_pkg::gtu_ctrl_s c;
    logic [11:0] mask;
    logic tick;
    logic slot;
    logic pe;
    logic le;
    logic a_e;
    logic b_e;
    logic a_l;
    logic b_l;
    logic dv;
    logic ev;
    logic evdn;
    logic go;
    logic pend_r;
    logic pdn_r;

    assign c = ctrl_r[i];
    assign mask = (12'((i < M1) ? `GTU_M1_BASE : `GTU_M2_BASE) << c.pre) - 12'h001;
    assign tick = (pre_r & mask) == 12'h000;
    // The first module is only served in every fourth cycle.
    assign slot = (i >= M1) || ((pre_r & MINM) == 12'h000);
    assign a_l = s2_r[i];
    assign b_l = s2_r[NT+i];
    assign a_e = rise[i] | fall[i];
    assign b_e = rise[NT+i] | fall[NT+i];
    assign pe = (c.edge_sel[0] & rise[i]) | (c.edge_sel[1] & fall[i]);
    assign dv = c.down ^ (c.ext_dir & b_l);

    // A core never counts on its own latch, which would close a loop.
    if (i == CORE) begin : g_core
      assign le = 1'b0;
    end else begin : g_aux
      assign le = (c.edge_sel[0] & lrise[LI]) | (c.edge_sel[1] & lfall[LI]);
    end

    always_comb begin
      ev = 1'b0;
      evdn = dv;
      unique case (c.mode)
        gtu_pkg::mode_timer: ev = tick;
        gtu_pkg::mode_counter: ev = c.lat_clk ? le : pe;
        gtu_pkg::mode_gate_lo: ev = tick & ~a_l;
        gtu_pkg::mode_gate_hi: ev = tick & a_l;
        gtu_pkg::mode_incr: begin
          ev = (i < M1) & (a_e | b_e);
          evdn = c.down ^ (a_e ? (a_l == b_l) : (a_l != b_l));
        end
        default: ev = 1'b0;
      endcase
    end

    assign go = ev & c.run;

    // An event between slots is held for the next slot; two events
    // inside one slot merge, which is the documented resolution limit.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pend_r <= 1'b0;
        pdn_r <= 1'b0;
      end else if (go && !slot) begin
        pend_r <= 1'b1;
        pdn_r <= evdn;
      end else if (slot) begin
        pend_r <= 1'b0;
      end
    end

    assign step[i] = slot & (go | pend_r);
    assign dn[i] = go ? evdn : pdn_r;
    assign ovf[i] = step[i] & (dn[i] ? (cnt_r[i] == 16'h0000) : (cnt_r[i] == TOP));

    if (i == 0 || i == 2) begin : g_role
      assign rl_trig[i] = (c.mode == gtu_pkg::mode_reload) &
                          (pe | (c.sel[0] & lrise[0]) | (c.sel[1] & lfall[0]));
      assign cp_trig[i] = (c.mode == gtu_pkg::mode_capture) & pe;
    end else begin : g_norole
      assign rl_trig[i] = 1'b0;
      assign cp_trig[i] = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Capture register trigger
  // ------------------------------------------------------------
  logic cr_rise;
  logic cr_fall;
  gtu_pkg::gtu_ctrl_s c5;

  assign c5 = ctrl_r[3];
  // Source zero is the capture pin; otherwise the first core's pins.
  assign cr_rise = (c5.sel == 2'h0) ? rise[2*NT] :
                   ((c5.sel[0] & rise[1]) | (c5.sel[1] & rise[NT+1]));
  assign cr_fall = (c5.sel == 2'h0) ? fall[2*NT] :
                   ((c5.sel[0] & fall[1]) | (c5.sel[1] & fall[NT+1]));
  assign cap_trig = (c5.edge_sel[0] & cr_rise) | (c5.edge_sel[1] & cr_fall);

  // ------------------------------------------------------------
  // Counters
  // ------------------------------------------------------------
  // Software writes win over hardware; a reload replaces the wrap value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NT; k++) begin
        cnt_r[k] <= `GTU_CNT_RST;
      end
    end else begin
      for (int k = 0; k < NT; k++) begin
        if (wr && cnt_sel[k]) begin
          cnt_r[k] <= merge(cnt_r[k], pwdata[15:0], pstrb[1:0]);
        end else if (k == 1 && (rl_trig[0] || rl_trig[2])) begin
          cnt_r[k] <= rl_trig[0] ? cnt_r[0] : cnt_r[2];
        end else if (k == 4 && ovf[4] && ctrl_r[4].lat_clk) begin
          cnt_r[k] <= capture_reload_register_r;
        end else if (cp_trig[k]) begin
          cnt_r[k] <= cnt_r[1];
        end else if (k == 3 && cap_trig && ctrl_r[3].clr_cap) begin
          cnt_r[k] <= 16'h0000;
        end else if (step[k]) begin
          cnt_r[k] <= dn[k] ? cnt_r[k] - 16'h0001 : cnt_r[k] + 16'h0001;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Capture register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_reload_register_r <= `GTU_CAP_RST;
    end else if (cap_trig) begin
      capture_reload_register_r <= cnt_r[3];
    end else if (wr && cap_sel) begin
      capture_reload_register_r <= merge(capture_reload_register_r, pwdata[15:0], pstrb[1:0]);
    end
  end

  // ------------------------------------------------------------
  // Request flags
  // ------------------------------------------------------------
  logic [`GTU_FLG_W-1:0] fset;
  logic [`GTU_FLG_W-1:0] fclr;

  assign fset = {cap_trig, ovf};
  assign fclr = (wr && flg_sel && pstrb[0]) ? pwdata[`GTU_FLG_W-1:0] : '0;

  // A new event in the clearing cycle survives.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= '0;
    end else begin
      flag_r <= (flag_r & ~fclr) | fset;
    end
  end

  // ------------------------------------------------------------
  // Toggle latches and outputs
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_r <= 2'h0;
    end else begin
      lat_r <= lat_r ^ {ovf[4], ovf[1]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_core_latch_pin <= 1'b0;
      second_core_latch_pin <= 1'b0;
      ccu_clock_en <= 1'b0;
    end else begin
      first_core_latch_pin <= lat_r[0] & ctrl_r[1].lat_oe;
      second_core_latch_pin <= lat_r[1] & ctrl_r[4].lat_oe;
      ccu_clock_en <= ovf[4];
    end
  end

endmodule
`default_nettype wire

// ---- shared/gtu_cfg.svh ----
// Register offsets, reset values and timing counts of the general timer unit.
`ifndef GTU_CFG_SVH
`define GTU_CFG_SVH

// ------------------------------------------------------------
// Register map (byte addresses, one 32-bit word per register)
// ------------------------------------------------------------
`define GTU_CNT_OFS 8'h00
`define GTU_CTL_OFS 8'h14
`define GTU_CAP_OFS 8'h28
`define GTU_FLG_OFS 8'h2C
`define GTU_REG_STEP 8'h04

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define GTU_FLG_CAP_BIT 5
`define GTU_FLG_W 6
`define GTU_CNT_RST 16'h0000
`define GTU_CTL_RST 16'h0000
`define GTU_CAP_RST 16'h0000

// ------------------------------------------------------------
// Timing counts in system clock cycles
// ------------------------------------------------------------
`define GTU_M1_MIN_CYC 4
`define GTU_M1_BASE 4
`define GTU_M2_BASE 2

`endif

// ---- shared/gtu_pkg.sv ----
// Types shared by the general timer unit and its bench.
package gtu_pkg;

  typedef enum logic [2:0] {
    mode_timer,
    mode_counter,
    mode_gate_lo,
    mode_gate_hi,
    mode_reload,
    mode_capture,
    mode_incr
  } gtu_mode_e;

  typedef struct packed {
    logic clr_cap;
    logic lat_oe;
    logic [1:0] sel;
    logic lat_clk;
    logic [1:0] edge_sel;
    logic ext_dir;
    logic down;
    logic run;
    logic [2:0] pre;
    gtu_mode_e mode;
  } gtu_ctrl_s;

  typedef struct packed {
    logic capture_trigger_pin;
    logic [4:0] timer_direction_pin;
    logic [4:0] timer_count_gate_pin;
  } gtu_pins_s;

endpackage
